// ### verilog/fbrg_pkg.sv
// How it works
// RQ1 - prescaler divides oscillator clock by one or four
// RQ2 - divisor spans one to 65536 minus sixteenth
// RQ3 - one sampling tick feeds transmitter and receiver
// RQ4 - reset loads low byte one, others zero
// RQ5 - high and low bytes form integer divisor
// RQ6 - fraction low nibble gives sixteenths
// RQ7 - fraction bits five, four select oversampling
// RQ8 - 8X doubles, 4X quadruples the rate
// RQ9 - divide-by-four prescaler quarters the rate
// RQ10 - 8X odd fraction may jitter one sixteenth
// RQ11 - 4X odd fraction may jitter one eighth
// RQ12 - software splits divisor into the three bytes
// RQ13 - register access never waits on rate clock
// RQ14 - reset restores divisor registers and outputs
// RQ15 - bit time is 16, 8 or 4 ticks
// RQ16 - fraction lengthens that many periods per sixteen
// RQ17 - integer part zero behaves as one
package fbrg_pkg;

  // ****************************************************************
  // clock and reset timing
  // ****************************************************************
  localparam int CLK_PERIOD_NS = 20;
  localparam int RESET_MIN_NS = 40;
  localparam int RESET_MIN_CYC =
    (RESET_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // ****************************************************************
  // reset values of the divisor registers
  // ****************************************************************
  localparam logic [7:0] DLOW_RESET = 8'h01;
  localparam logic [7:0] DHIGH_RESET = 8'h00;
  localparam logic [7:0] DFRAC_RESET = 8'h00;

  // ****************************************************************
  // field positions in the fraction and sampling register
  // ****************************************************************
  localparam int FRAC_LSB = 0;
  localparam int FRAC_W = 4;
  localparam int MODE_LSB = 4;
  localparam int MODE_W = 2;
  // prescaler select position in the modem control register
  localparam int PRESC_BIT = 7;

  // ****************************************************************
  // read selector codes
  // ****************************************************************
  localparam logic [1:0] RSEL_LOW = 2'h0;
  localparam logic [1:0] RSEL_HIGH = 2'h1;
  localparam logic [1:0] RSEL_FRAC = 2'h2;

  // ****************************************************************
  // sampling modes and bit lengths in sampling ticks
  // ****************************************************************
  typedef enum logic [1:0] {
    FBRG_X16 = 2'b00,
    FBRG_X8 = 2'b01,
    FBRG_X4 = 2'b10,
    FBRG_XRSV = 2'b11
  } fbrg_mode_t;

  localparam logic [4:0] BITLEN_X16 = 5'h10;
  localparam logic [4:0] BITLEN_X8 = 5'h08;
  localparam logic [4:0] BITLEN_X4 = 5'h04;

  // ****************************************************************
  // carriers
  // ****************************************************************
  typedef struct packed {
    logic low_we;
    logic high_we;
    logic frac_we;
    logic [7:0] data;
  } fbrg_wr_t;

  typedef struct packed {
    logic [7:0] divisor_low_byte;
    logic [7:0] divisor_high_byte;
    logic [7:0] divisor_fraction_and_sampling;
  } fbrg_cfg_t;

endpackage

// ### verilog/fbrg_prescaler.sv
`timescale 1ns/1ps
module fbrg_prescaler
(
  input wire logic clk_sys_i,
  input wire logic srst_i,
  input wire logic by4_i,
  input wire logic restart_i,
  output logic tick_o
);
  import fbrg_pkg::*;

  logic [1:0] cnt_r;
  logic [1:0] cnt_nxt;
  logic tick_r;
  logic tick_nxt;

  // ****************************************************************
  // divide by one or by four
  // ****************************************************************

  // next count and enable pulse
  always_comb
  begin
    cnt_nxt = cnt_r + 2'h1;
    tick_nxt = 1'b1;
    // RQ1 select one or four
    if (by4_i)
    begin
      tick_nxt = (cnt_r == 2'h3);
    end
    if (restart_i)
    begin
      cnt_nxt = 2'h0;
      tick_nxt = 1'b0;
    end
  end

  // register stage
  always_ff @(posedge clk_sys_i)
  begin
    if (srst_i)
    begin
      cnt_r <= 2'h0;
      tick_r <= 1'b0;
    end
    else
    begin
      cnt_r <= cnt_nxt;
      tick_r <= tick_nxt;
    end
  end

  assign tick_o = tick_r;

endmodule // fbrg_prescaler

// ### verilog/fbrg_core.sv
`timescale 1ns/1ps
module fbrg_core
(
  input wire logic clk_sys_i,
  input wire logic srst_i,
  input wire fbrg_pkg::fbrg_wr_t wr_i,
  input wire logic [7:0] modem_control_reg_i,
  input wire logic [1:0] rd_sel_i,
  output logic [7:0] rd_data_o,
  output fbrg_pkg::fbrg_cfg_t cfg_o,
  output logic sample_tick_o,
  output logic bit_tick_o
);
  import fbrg_pkg::*;

  // ****************************************************************
  // helper functions
  // ****************************************************************

  // integer part with zero promoted to one
  function automatic logic [15:0] int_divisor(input logic [7:0] hi,
                                               input logic [7:0] lo);
    logic [15:0] raw;
    raw = {hi, lo};
    // RQ17 zero acts as one
    if (raw == 16'h0000)
    begin
      raw = 16'h0001;
    end
    return raw;
  endfunction

  // sixteenths from the fraction register
  function automatic logic [3:0] frac_of(input logic [7:0] reg_v);
    return reg_v[FRAC_LSB +: FRAC_W];
  endfunction

  // sampling mode from the fraction register
  function automatic fbrg_mode_t mode_of(input logic [7:0] reg_v);
    return fbrg_mode_t'(reg_v[MODE_LSB +: MODE_W]);
  endfunction

  // ticks per bit for a mode
  function automatic logic [4:0] bit_len(input fbrg_mode_t m);
    logic [4:0] len;
    len = BITLEN_X16;
    unique case (m)
      FBRG_X16: len = BITLEN_X16;
      FBRG_X8: len = BITLEN_X8;
      FBRG_X4: len = BITLEN_X4;
      FBRG_XRSV: len = BITLEN_X16;
    endcase
    return len;
  endfunction

  // ****************************************************************
  // divisor register file
  // ****************************************************************

  logic [7:0] low_r;
  logic [7:0] low_nxt;
  logic [7:0] high_r;
  logic [7:0] high_nxt;
  logic [7:0] frac_r;
  logic [7:0] frac_nxt;
  logic restart_w;

  // writes land at once, no rate clock needed
  always_comb
  begin
    low_nxt = low_r;
    high_nxt = high_r;
    frac_nxt = frac_r;
    // RQ13 direct register write
    if (wr_i.low_we)
    begin
      low_nxt = wr_i.data;
    end
    if (wr_i.high_we)
    begin
      high_nxt = wr_i.data;
    end
    if (wr_i.frac_we)
    begin
      frac_nxt = wr_i.data;
    end
  end

  // any divisor write restarts the divider chain
  assign restart_w = wr_i.low_we | wr_i.high_we | wr_i.frac_we;

  // register stage with reset defaults
  always_ff @(posedge clk_sys_i)
  begin
    // RQ4 divisor resets to one
    if (srst_i)
    begin
      low_r <= DLOW_RESET;
      high_r <= DHIGH_RESET;
      frac_r <= DFRAC_RESET;
    end
    else
    begin
      low_r <= low_nxt;
      high_r <= high_nxt;
      frac_r <= frac_nxt;
    end
  end

  // ****************************************************************
  // prescaler
  // ****************************************************************

  logic presc_tick_w;

  // RQ9 quarter rate when set
  fbrg_prescaler u_presc
  (
    .clk_sys_i(clk_sys_i),
    .srst_i(srst_i),
    .by4_i(modem_control_reg_i[PRESC_BIT]),
    .restart_i(restart_w),
    .tick_o(presc_tick_w)
  );

  // ****************************************************************
  // fractional rate divider
  // ****************************************************************

  logic [16:0] cnt_r;
  logic [16:0] cnt_nxt;
  logic [3:0] acc_r;
  logic [3:0] acc_nxt;
  logic ext_r;
  logic ext_nxt;
  logic sample_r;
  logic sample_nxt;
  logic [16:0] last_w;
  logic [4:0] acc_sum_w;

  // RQ5 integer from both bytes
  assign last_w = {1'b0, int_divisor(high_r, low_r)} - 17'h00001
                  + {16'h0000, ext_r};

  // RQ6 sixteenths accumulate
  assign acc_sum_w = {1'b0, acc_r} + {1'b0, frac_of(frac_r)};

  // count prescaled ticks, stretch some periods by one
  always_comb
  begin
    cnt_nxt = cnt_r;
    acc_nxt = acc_r;
    ext_nxt = ext_r;
    sample_nxt = 1'b0;
    if (restart_w)
    begin
      cnt_nxt = 17'h00000;
      acc_nxt = 4'h0;
      ext_nxt = 1'b0;
    end
    else if (presc_tick_w)
    begin
      // RQ2 period reaches divisor
      if (cnt_r >= last_w)
      begin
        cnt_nxt = 17'h00000;
        sample_nxt = 1'b1;
        // RQ16 carry spreads stretches
        acc_nxt = acc_sum_w[3:0];
        ext_nxt = acc_sum_w[4];
      end
      else
      begin
        cnt_nxt = cnt_r + 17'h00001;
      end
    end
  end

  // register stage
  always_ff @(posedge clk_sys_i)
  begin
    if (srst_i)
    begin
      cnt_r <= 17'h00000;
      acc_r <= 4'h0;
      ext_r <= 1'b0;
      sample_r <= 1'b0;
    end
    else
    begin
      cnt_r <= cnt_nxt;
      acc_r <= acc_nxt;
      ext_r <= ext_nxt;
      sample_r <= sample_nxt;
    end
  end

  // ****************************************************************
  // bit time counter
  // ****************************************************************

  logic [3:0] bcnt_r;
  logic [3:0] bcnt_nxt;
  logic bit_r;
  logic bit_nxt;
  logic [4:0] len_w;

  // RQ7 mode picks oversampling
  assign len_w = bit_len(mode_of(frac_r));

  // count sampling ticks per bit
  always_comb
  begin
    bcnt_nxt = bcnt_r;
    bit_nxt = 1'b0;
    if (restart_w)
    begin
      bcnt_nxt = 4'h0;
    end
    else if (sample_r)
    begin
      // RQ15 ticks per bit
      if ({1'b0, bcnt_r} >= len_w - 5'h01)
      begin
        bcnt_nxt = 4'h0;
        // RQ8 fewer ticks, faster bit
        bit_nxt = 1'b1;
      end
      else
      begin
        bcnt_nxt = bcnt_r + 4'h1;
      end
    end
  end

  // register stage
  always_ff @(posedge clk_sys_i)
  begin
    if (srst_i)
    begin
      bcnt_r <= 4'h0;
      bit_r <= 1'b0;
    end
    else
    begin
      bcnt_r <= bcnt_nxt;
      bit_r <= bit_nxt;
    end
  end

  // ****************************************************************
  // register read back
  // ****************************************************************

  logic [7:0] rd_r;
  logic [7:0] rd_nxt;

  // select register, others read zero
  always_comb
  begin
    rd_nxt = 8'h00;
    unique case (rd_sel_i)
      RSEL_LOW: rd_nxt = low_r;
      RSEL_HIGH: rd_nxt = high_r;
      RSEL_FRAC: rd_nxt = frac_r;
      default: rd_nxt = 8'h00;
    endcase
  end

  // register stage
  always_ff @(posedge clk_sys_i)
  begin
    // RQ14 outputs to defaults
    if (srst_i)
    begin
      rd_r <= 8'h00;
    end
    else
    begin
      rd_r <= rd_nxt;
    end
  end

  // ****************************************************************
  // outputs
  // ****************************************************************

  // configuration straight from the registers
  assign cfg_o.divisor_low_byte = low_r;
  assign cfg_o.divisor_high_byte = high_r;
  assign cfg_o.divisor_fraction_and_sampling = frac_r;
  assign rd_data_o = rd_r;

  // RQ3 one tick for both sides
  assign sample_tick_o = sample_r;
  // RQ10 RQ11 jitter from stretch pattern
  assign bit_tick_o = bit_r;

endmodule // fbrg_core

// ### bench/fbrg_props.sv
`timescale 1ns/1ps
// ****************************************************************
// port checker for the rate generator
// ****************************************************************
module fbrg_props
(
  input wire logic clk_sys_i,
  input wire logic srst_i,
  input wire fbrg_pkg::fbrg_wr_t wr_i,
  input wire logic [7:0] modem_control_reg_i,
  input wire logic [1:0] rd_sel_i,
  input wire logic [7:0] rd_data_o,
  input wire fbrg_pkg::fbrg_cfg_t cfg_o,
  input wire logic sample_tick_o,
  input wire logic bit_tick_o
);
  import fbrg_pkg::*;
  logic any_we;
  logic n1_by1;
  logic [3:0] quiet_r;
  logic [3:0] quiet_nxt;
  logic mcr7_r;
  logic mcr7_nxt;
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (srst_i);
  // any write restarts the whole chain
  assign any_we = wr_i.low_we || wr_i.high_we || wr_i.frac_we;
  // divisor one, no prescale, settled for eight cycles
  assign n1_by1 = cfg_o.divisor_low_byte == 8'h01 &&
    cfg_o.divisor_high_byte == 8'h00 && !modem_control_reg_i[7] &&
    !mcr7_r &&
    cfg_o.divisor_fraction_and_sampling[3:0] == 4'h0 && quiet_r >= 4'h8;
  // cycles since last write or prescaler change
  always_comb
  begin
    quiet_nxt = quiet_r;
    if (any_we || modem_control_reg_i[7] != mcr7_r)
      quiet_nxt = 4'h0;
    else if (quiet_r != 4'hf)
      quiet_nxt = quiet_r + 4'h1;
    mcr7_nxt = modem_control_reg_i[7];
    if (srst_i)
    begin
      quiet_nxt = 4'h0;
      mcr7_nxt = 1'b0;
    end
  end
  // helper registers
  always_ff @(posedge clk_sys_i)
  begin
    quiet_r <= quiet_nxt;
    mcr7_r <= mcr7_nxt;
  end
  // 4x bit tick start and its spacing
  sequence s_x4_start;
    bit_tick_o && n1_by1 && cfg_o.divisor_fraction_and_sampling[5:4] == 2'h2;
  endsequence
  sequence s_gap4;
    (!bit_tick_o)[*3] ##1 bit_tick_o;
  endsequence
  property p_rst;
    disable iff (1'b0) $fell(srst_i) |-> cfg_o == {DLOW_RESET, DHIGH_RESET,
      DFRAC_RESET} && rd_data_o == 8'h00 && !sample_tick_o;
  endproperty
  // ****************************************************************
  // assertions
  // ****************************************************************
  a_reset_values: assert property (p_rst)
    else $error("registers not at reset values");
  a_low_store: assert property (wr_i.low_we |=>
    cfg_o.divisor_low_byte == $past(wr_i.data)) else $error("low byte lost");
  a_frac_store: assert property (wr_i.frac_we |=>
    cfg_o.divisor_fraction_and_sampling == $past(wr_i.data))
    else $error("fraction lost");
  a_high_read: assert property (rd_sel_i == RSEL_HIGH |=>
    rd_data_o == $past(cfg_o.divisor_high_byte)) else $error("bad read");
  a_sel3_zero: assert property (rd_sel_i == 2'h3 |=>
    rd_data_o == 8'h00) else $error("unused select not zero");
  a_bit_pulse: assert property (bit_tick_o |=> !bit_tick_o)
    else $error("bit tick too long");
  a_x4_bit_gap: assert property (s_x4_start |=> s_gap4)
    else $error("4x bit time wrong");
  a_n1_every_cycle: assert property (sample_tick_o && n1_by1 |=>
    sample_tick_o || $past(any_we)) else $error("divisor one skipped");
  a_by4_gap: assert property (sample_tick_o && modem_control_reg_i[7] &&
    mcr7_r && quiet_r >= 4'h8 |=> (!sample_tick_o)[*3])
    else $error("by4 too fast");
endmodule // fbrg_props

bind fbrg_core fbrg_props u_props
(
  .clk_sys_i(clk_sys_i),
  .srst_i(srst_i),
  .wr_i(wr_i),
  .modem_control_reg_i(modem_control_reg_i),
  .rd_sel_i(rd_sel_i),
  .rd_data_o(rd_data_o),
  .cfg_o(cfg_o),
  .sample_tick_o(sample_tick_o),
  .bit_tick_o(bit_tick_o)
);

// ### bench/tb.sv
`timescale 1ns/1ps
// ****************************************************************
// self-checking bench for the rate generator
// ****************************************************************
module tb;
  import fbrg_pkg::*;
  logic clk_sys_i;
  logic srst_i;
  fbrg_wr_t wr_i;
  logic [7:0] modem_control_reg_i;
  logic [1:0] rd_sel_i;
  logic [7:0] rd_data_o;
  fbrg_cfg_t cfg_o;
  logic sample_tick_o;
  logic bit_tick_o;
  int bad_count;
  int total_checks;

  fbrg_core dut
  (
    .clk_sys_i(clk_sys_i),
    .srst_i(srst_i),
    .wr_i(wr_i),
    .modem_control_reg_i(modem_control_reg_i),
    .rd_sel_i(rd_sel_i),
    .rd_data_o(rd_data_o),
    .cfg_o(cfg_o),
    .sample_tick_o(sample_tick_o),
    .bit_tick_o(bit_tick_o)
  );

  // 50 MHz clock
  initial
  begin
    clk_sys_i = 1'b0;
    forever #10 clk_sys_i = ~clk_sys_i;
  end

  // ****************************************************************
  // helpers
  // ****************************************************************
  task automatic conclude();
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  task automatic check(input logic [23:0] seen, input logic [23:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("BAD %0t got %h want %h", $time, seen, exp);
    end
  endtask

  // inputs move just after each rising edge
  task automatic cyc();
    @(posedge clk_sys_i);
    #2;
  endtask

  task automatic rd(input logic [1:0] s, input logic [7:0] e);
    rd_sel_i = s;
    cyc();
    check({16'h0000, rd_data_o}, {16'h0000, e});
  endtask

  // back-to-back writes of low, high, fraction
  task automatic cfg(input logic [7:0] hi, lo, fr);
    wr_i = {3'b100, lo};
    cyc();
    wr_i = {3'b010, hi};
    cyc();
    wr_i = {3'b001, fr};
    cyc();
    wr_i = '0;
  endtask

  // cycles spanned by n tick periods, bounded wait
  task automatic span(input logic bt, input int n, output logic [15:0] c);
    int lim;
    int k;
    lim = 0;
    k = 0;
    c = 16'h0000;
    while ((bt ? bit_tick_o : sample_tick_o) !== 1'b1 && lim < 3000)
    begin
      cyc();
      lim++;
    end
    while (k < n && lim < 3000)
    begin
      cyc();
      c++;
      lim++;
      if ((bt ? bit_tick_o : sample_tick_o) === 1'b1)
        k++;
    end
    if (lim >= 3000)
    begin
      bad_count++;
      $display("BAD %0t tick wait ran out", $time);
      conclude();
    end
  endtask

  task automatic row(input logic [7:0] hi, lo, fr, m, input int n,
    input logic [15:0] e, input logic bt);
    logic [15:0] c;
    modem_control_reg_i = m;
    cyc();
    cfg(hi, lo, fr);
    span(bt, n, c);
    check({8'h00, c}, {8'h00, e});
  endtask

  // ****************************************************************
  // scenarios
  // ****************************************************************
  task automatic t_reset();
    rd(RSEL_LOW, 8'h01);
    rd(RSEL_HIGH, 8'h00);
    rd(RSEL_FRAC, 8'h00);
    check(cfg_o, 24'h010000);
  endtask

  task automatic t_regs();
    cfg(8'h0e, 8'ha6, 8'h2b);
    rd(RSEL_LOW, 8'ha6);
    rd(RSEL_HIGH, 8'h0e);
    rd(RSEL_FRAC, 8'h2b);
    rd(2'h3, 8'h00);
    check(cfg_o, 24'ha60e2b);
  endtask

  task automatic t_rate();
    row(8'h00, 8'h05, 8'h00, 8'h00, 4, 16'd20, 1'b0);
    row(8'h00, 8'h05, 8'h00, 8'h80, 4, 16'd80, 1'b0);
    row(8'h00, 8'h03, 8'h04, 8'h00, 16, 16'd52, 1'b0);
    row(8'h00, 8'h02, 8'h0f, 8'h00, 16, 16'd47, 1'b0);
    row(8'h00, 8'h00, 8'h00, 8'h00, 8, 16'd8, 1'b0);
    row(8'h01, 8'h00, 8'h00, 8'h00, 1, 16'd256, 1'b0);
  endtask

  // zero-fraction 4x row last so no write lands inside a checked 4x bit time
  task automatic t_modes();
    row(8'h00, 8'h01, 8'h00, 8'h00, 3, 16'd48, 1'b1);
    row(8'h00, 8'h01, 8'h30, 8'h00, 3, 16'd48, 1'b1);
    row(8'h00, 8'h01, 8'h10, 8'h00, 3, 16'd24, 1'b1);
    row(8'h00, 8'h01, 8'h12, 8'h00, 2, 16'd18, 1'b1);
    row(8'h00, 8'h01, 8'h25, 8'h00, 4, 16'd21, 1'b1);
    row(8'h00, 8'h01, 8'h20, 8'h00, 3, 16'd12, 1'b1);
  endtask

  task automatic t_rerun();
    srst_i = 1'b1;
    repeat (RESET_MIN_CYC) cyc();
    srst_i = 1'b0;
    t_reset();
  endtask

  // main sequence
  initial
  begin
    bad_count = 0;
    total_checks = 0;
    srst_i = 1'b1;
    wr_i = '0;
    modem_control_reg_i = 8'h00;
    rd_sel_i = 2'h0;
    repeat (5) cyc();
    srst_i = 1'b0;
    t_reset();
    t_regs();
    t_rate();
    t_modes();
    t_rerun();
    conclude();
  end
endmodule // tb
